//--- nme_pkg.sv
// Shared constants, state encodings and state record of the nibble MCU core
package nme_pkg;

  // Register port offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ROM_ADDR = 8'h04;
  localparam logic [7:0] OFF_ROM_DATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PORTS = 8'h10;

  // Memory geometry
  localparam int ROM_WORDS = 1024;
  localparam int RAM_WORDS = 64;

  // Counts and limits
  localparam logic [9:0] TBC_MAX = 10'h3FF;
  localparam logic [9:0] PC_STEP = 10'h001;
  localparam logic [3:0] BD_MIN = 4'h0;
  localparam logic [3:0] BD_MAX = 4'hF;
  localparam logic [3:0] BD_STEP = 4'h1;
  localparam logic [1:0] IL_LOW_MIN = 2'h1;
  localparam logic [1:0] IL_CNT_STEP = 2'h1;
  localparam logic [3:0] SUB_PAGE = 4'h2;

  // First-byte opcodes
  localparam logic [7:0] OP_CLRA = 8'h00;
  localparam logic [7:0] OP_PFX_DIR = 8'h23;
  localparam logic [7:0] OP_PFX_EXT = 8'h33;
  localparam logic [7:0] OP_SC = 8'h22;
  localparam logic [7:0] OP_RC = 8'h32;
  localparam logic [7:0] OP_SKT = 8'h41;
  localparam logic [7:0] OP_CBA = 8'h4E;
  localparam logic [7:0] OP_XAS = 8'h4F;
  localparam logic [7:0] OP_CAB = 8'h50;
  localparam logic [7:0] OP_TABLE_LOOKUP = 8'hBF;
  localparam logic [7:0] OP_JID = 8'hFF;
  localparam logic [3:0] HI_STORE_IMMEDIATE_ADVANCE = 4'h7;

  // Second-byte opcodes after the extended prefix
  localparam logic [7:0] OP2_TEST_PORT_ALL_ZERO = 8'h21;
  localparam logic [7:0] OP2_READ_PULSE_LATCHES = 8'h29;
  localparam logic [7:0] OP2_ING = 8'h2A;
  localparam logic [7:0] OP2_INL = 8'h2E;
  localparam logic [3:0] HI_OGI = 4'h5;
  localparam logic [3:0] HI_LEI = 4'h6;

  typedef enum logic [1:0] {ST_FETCH, ST_OP2, ST_IND} nme_state_e;

  typedef struct packed {
    nme_state_e st;
    logic run;
    logic [9:0] pc;
    logic [3:0] a;
    logic c;
    logic [1:0] br;
    logic [3:0] bd;
    logic [9:0] sa;
    logic [9:0] sb;
    logic [9:0] sc;
    logic [7:0] q;
    logic [3:0] g;
    logic [3:0] en;
    logic [3:0] serial_shift_counter;
    logic skl;
    logic skip;
    logic lbi_run;
    logic pfx_ext;
    logic ind_table_lookup;
    logic [9:0] ind_addr;
    logic [9:0] rom_ptr;
    logic [9:0] tbc;
    logic tflag;
    logic [3:0] g_s1;
    logic [3:0] g_s2;
    logic [7:0] l_s1;
    logic [7:0] l_s2;
    logic [1:0] in_s1;
    logic [1:0] in_s2;
    logic cko_s1;
    logic cko_s2;
    logic [1:0] armed;
    logic [3:0] lowc;
    logic [31:0] rdata;
  } nme_regs_s;

  localparam nme_regs_s REGS_RST = '0;

endpackage

//--- nme_core.sv
// Execution core of the nibble MCU: decode, skips, ports, timer, latches
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
// What this block does
// - Six-bit RAM pointer: two-bit row_index above four-bit digit_index.
// - store_immediate_advance writes operand to RAM, increments digit_index, never skips.
// - swap_and_step_down swaps, decrements digit, XORs row; skips on wrap below 0.
// - swap_and_step_up swaps, increments digit, XORs row; skips on wrap past 15.
// - swap_direct (23 prefix) swaps accumulator with RAM word at r,d.
// - Single-byte load_pointer_immediate encodes d minus one in its low nibble.
// - After load_pointer_immediate, following ones are passed over until another type.
// - load_function_select_immediate (33 prefix) loads the function select latch.
// - test_port_all_zero skips when all four G bits read zero.
// - test_port_bit_zero skips when the selected G bit is zero.
// - test_ram_bit_zero skips when the selected addressed RAM bit is zero.
// - read_port_l puts L high nibble in RAM, low nibble in accumulator.
// - write_port_g_immediate latches its operand into the G output register.
// - acc_serial_swap swaps accumulator with serial counter, copies carry to clock.
// - indirect_jump loads PC low byte from ROM, keeps bits 9:8, two cycles.
// - Pulse latch sets after a falling input stays low two cycles.
// - read_pulse_latches returns latch3, clock pin or one, zero, latch0; clears.
// - Reset leaves the pulse latches untouched.
// - table_lookup loads ROM byte into output latch; level two moves to three.
// - Ten-bit time base overflows every 1024 cycles; timer test skips, clears.
// - Skipped bytes take one cycle each; indirect ops take two, one skipped.
// - Sixteen pages of 64 words; last-word page operations act on next page.
// - page_jump spans pages 2 and 3 there, else stays in current page.
// - call_page_two pushes return and loads 0010 into PC bits 9:6.
module nme_core
  import nme_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic [3:0] g_in,
  output logic [3:0] g_out,
  output logic [3:0] g_oe_n,
  input wire logic [7:0] l_in,
  input wire logic in3_pin,
  input wire logic in0_pin,
  input wire logic cko_pin,
  input wire logic cko_gp_opt,
  output logic [7:0] q_out,
  output logic [3:0] en_out,
  output logic sk_out
);

  nme_regs_s r;
  nme_regs_s nx;

  logic [7:0] rom [ROM_WORDS];
  logic [3:0] ram [RAM_WORDS];
  logic [1:0] il;

  logic [7:0] op;
  logic [7:0] rom_q;
  logic [9:0] pcn;
  logic [5:0] ram_ra;
  logic [3:0] m;
  logic ram_we;
  logic [3:0] ram_wd;
  logic rom_we;
  logic il_clr;
  logic [1:0] il_set;
  logic tclr;
  logic tovf;
  logic cko_val;
  logic fetch_ex;
  logic op2_ex;

  function automatic logic is_lbi(input logic [7:0] b);
    return (b[7:6] == 2'h0) && b[3];
  endfunction

  function automatic logic is_pfx(input logic [7:0] b);
    return (b == OP_PFX_DIR) || (b == OP_PFX_EXT);
  endfunction

  function automatic logic [1:0] bit_sel(input logic [7:0] b);
    return {b[1], b[4]};
  endfunction

  assign op = rom[r.pc];
  assign rom_q = rom[r.ind_addr];
  // Counting through page boundaries puts a last-word operation in the next page
  assign pcn = r.pc + PC_STEP;
  assign ram_ra = (r.st == ST_OP2 && !r.pfx_ext) ? op[5:0] : {r.br, r.bd};
  assign m = ram[ram_ra];
  assign cko_val = cko_gp_opt ? r.cko_s2 : 1'b1;
  assign tovf = (r.tbc == TBC_MAX);
  assign fetch_ex = ce && r.run && (r.st == ST_FETCH) && !r.skip &&
                    !(r.lbi_run && is_lbi(op));
  assign op2_ex = ce && (r.st == ST_OP2) && !r.skip && r.pfx_ext;

  always_comb begin
    nx = r;
    ram_we = 1'b0;
    ram_wd = r.a;
    rom_we = 1'b0;
    il_clr = 1'b0;
    il_set = 2'h0;
    tclr = 1'b0;

    // Pin synchronisers
    nx.g_s1 = g_in;
    nx.g_s2 = r.g_s1;
    nx.l_s1 = l_in;
    nx.l_s2 = r.l_s1;
    nx.in_s1 = {in3_pin, in0_pin};
    nx.in_s2 = r.in_s1;
    nx.cko_s1 = cko_pin;
    nx.cko_s2 = r.cko_s1;

    // Time base
    nx.tbc = r.tbc + PC_STEP;

    // Falling-edge catch: armed by a high, fires on the second low cycle
    for (int i = 0; i < 2; i++) begin
      if (r.in_s2[i]) begin
        nx.armed[i] = 1'b1;
        nx.lowc[2*i +: 2] = 2'h0;
      end else if (r.armed[i]) begin
        if (r.lowc[2*i +: 2] == IL_LOW_MIN) begin
          il_set[i] = 1'b1;
          nx.armed[i] = 1'b0;
        end else begin
          nx.lowc[2*i +: 2] = r.lowc[2*i +: 2] + IL_CNT_STEP;
        end
      end
    end

    unique case (r.st)
      ST_FETCH: begin
        if (r.run) begin
          nx.pc = pcn;
          if (r.skip && is_pfx(op)) begin
            nx.st = ST_OP2;
          end else if (r.skip) begin
            nx.skip = 1'b0;
          end else if (r.lbi_run && is_lbi(op)) begin
            nx.skip = 1'b0;
          end else begin
            nx.lbi_run = 1'b0;
            casez (op)
              OP_CLRA: nx.a = BD_MIN;
              OP_PFX_DIR, OP_PFX_EXT: begin
                nx.st = ST_OP2;
                nx.pfx_ext = (op == OP_PFX_EXT);
              end
              OP_SC: nx.c = 1'b1;
              OP_RC: nx.c = 1'b0;
              OP_CAB: nx.bd = r.a;
              OP_CBA: nx.a = r.bd;
              {HI_STORE_IMMEDIATE_ADVANCE, 4'h?}: begin
                ram_we = 1'b1;
                ram_wd = op[3:0];
                nx.bd = r.bd + BD_STEP;
              end
              8'b00??0111: begin
                ram_we = 1'b1;
                nx.a = m;
                nx.bd = r.bd - BD_STEP;
                nx.br = r.br ^ op[5:4];
                nx.skip = (r.bd == BD_MIN);
              end
              8'b00??0100: begin
                ram_we = 1'b1;
                nx.a = m;
                nx.bd = r.bd + BD_STEP;
                nx.br = r.br ^ op[5:4];
                nx.skip = (r.bd == BD_MAX);
              end
              8'b00??0110: begin
                ram_we = 1'b1;
                nx.a = m;
                nx.br = r.br ^ op[5:4];
              end
              8'b00??_1???: begin
                nx.br = op[5:4];
                nx.bd = op[3:0] + BD_STEP;
                nx.lbi_run = 1'b1;
              end
              8'b000?_00?1: nx.skip = !m[bit_sel(op)];
              OP_SKT: begin
                if (r.tflag) begin
                  nx.skip = 1'b1;
                  tclr = 1'b1;
                end
              end
              OP_XAS: begin
                nx.a = r.serial_shift_counter;
                nx.serial_shift_counter = r.a;
                nx.skl = r.c;
              end
              OP_JID, OP_TABLE_LOOKUP: begin
                nx.st = ST_IND;
                nx.ind_addr = {pcn[9:8], r.a, m};
                nx.ind_table_lookup = (op == OP_TABLE_LOOKUP);
              end
              8'b1???_????: begin
                if (pcn[9:7] == SUB_PAGE[3:1]) begin
                  nx.pc = {pcn[9:7], op[6:0]};
                end else if (op[6]) begin
                  nx.pc = {pcn[9:6], op[5:0]};
                end else begin
                  nx.sa = pcn;
                  nx.sb = r.sa;
                  nx.sc = r.sb;
                  nx.pc = {SUB_PAGE, op[5:0]};
                end
              end
              default: nx.lbi_run = 1'b0;
            endcase
          end
        end
      end
      ST_OP2: begin
        nx.pc = pcn;
        nx.st = ST_FETCH;
        if (r.skip) begin
          nx.skip = 1'b0;
        end else if (!r.pfx_ext) begin
          nx.a = m;
          if (op[7]) begin
            ram_we = 1'b1;
          end
        end else begin
          casez (op)
            OP2_TEST_PORT_ALL_ZERO: nx.skip = (r.g_s2 == BD_MIN);
            8'b000?_00?1: nx.skip = !r.g_s2[bit_sel(op)];
            OP2_ING: nx.a = r.g_s2;
            OP2_INL: begin
              ram_we = 1'b1;
              ram_wd = r.l_s2[7:4];
              nx.a = r.l_s2[3:0];
            end
            OP2_READ_PULSE_LATCHES: begin
              nx.a = {il[1], cko_val, 1'b0, il[0]};
              il_clr = 1'b1;
            end
            {HI_OGI, 4'h?}: nx.g = op[3:0];
            {HI_LEI, 4'h?}: nx.en = op[3:0];
            8'b10??_????: begin
              nx.br = op[5:4];
              nx.bd = op[3:0];
              nx.lbi_run = 1'b1;
            end
            default: nx.skip = 1'b0;
          endcase
        end
      end
      ST_IND: begin
        nx.st = ST_FETCH;
        if (r.ind_table_lookup) begin
          nx.q = rom_q;
          nx.sc = r.sb;
        end else begin
          nx.pc = {r.pc[9:8], rom_q};
        end
      end
    endcase

    // Overflow set wins over a timer-test clear in the same cycle
    nx.tflag = tovf | (r.tflag & ~tclr);

    // Register port
    if (bus_wr) begin
      case (bus_addr)
        OFF_CTRL: nx.run = bus_wdata[0];
        OFF_ROM_ADDR: nx.rom_ptr = bus_wdata[9:0];
        OFF_ROM_DATA: begin
          rom_we = 1'b1;
          nx.rom_ptr = r.rom_ptr + PC_STEP;
        end
        default: nx.rdata = r.rdata;
      endcase
    end
    nx.rdata = 32'h0;
    if (bus_rd) begin
      case (bus_addr)
        OFF_CTRL: nx.rdata = {31'h0, r.run};
        OFF_ROM_ADDR: nx.rdata = {22'h0, r.rom_ptr};
        OFF_ROM_DATA: nx.rdata = {24'h0, rom[r.rom_ptr]};
        OFF_STATUS: nx.rdata = {10'h0, r.skip, r.c, r.a, r.br, r.bd, r.pc};
        OFF_PORTS: nx.rdata = {9'h0, r.tflag, il, r.serial_shift_counter, r.en, r.g, r.q};
        default: nx.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= REGS_RST;
    end else if (ce) begin
      r <= nx;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && rom_we) begin
      rom[r.rom_ptr] <= bus_wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (ce && ram_we) begin
      ram[ram_ra] <= ram_wd;
    end
  end

  // Catch latches carry no reset so their contents survive a device reset
  for (genvar i = 0; i < 2; i++) begin : g_il
    always_ff @(posedge clk) begin
      if (ce && (il_set[i] || il_clr)) begin
        il[i] <= il_set[i];
      end
    end
  end

  assign bus_rdata = r.rdata;
  assign g_out = r.g;
  // Open-drain G: pulled low where the latch holds zero, released otherwise
  assign g_oe_n = r.g;
  assign q_out = r.q;
  assign en_out = r.en;
  assign sk_out = r.skl;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_ind_then_fetch;
    (r.st == ST_IND) ##1 (r.st == ST_FETCH);
  endsequence

  AST_STORE_IMMEDIATE_ADVANCE: assert property (
    fetch_ex && op[7:4] == HI_STORE_IMMEDIATE_ADVANCE |=>
      r.bd == $past(r.bd) + BD_STEP && !r.skip)
    else $error("store advance did not step digit");

  AST_XDS: assert property (
    fetch_ex && op[7:6] == 2'h0 && op[3:0] == 4'h7 && r.bd == BD_MIN |=>
      r.skip && r.bd == BD_MAX)
    else $error("step down wrap did not skip");

  AST_XIS: assert property (
    fetch_ex && op[7:6] == 2'h0 && op[3:0] == 4'h4 && r.bd == BD_MAX |=>
      r.skip && r.bd == BD_MIN)
    else $error("step up wrap did not skip");

  AST_LBI_CHAIN: assert property (
    ce && r.run && r.st == ST_FETCH && !r.skip && r.lbi_run && is_lbi(op)
      |=> $stable(r.br) && $stable(r.bd))
    else $error("chained pointer load was not passed over");

  AST_OGI: assert property (
    op2_ex && op[7:4] == HI_OGI |=> g_out == $past(op[3:0]))
    else $error("G latch missed immediate");

  AST_JID: assert property (
    fetch_ex && op == OP_JID ##1 ce |->
      s_ind_then_fetch and (r.pc[9:8] == $past(pcn[9:8])))
    else $error("indirect jump sequence wrong");

  AST_READ_PULSE_LATCHES: assert property (
    op2_ex && op == OP2_READ_PULSE_LATCHES |=>
      r.a[1] == 1'b0 && r.a[0] == $past(il[0]) && r.a[3] == $past(il[1]))
    else $error("latch read returned wrong bits");

  AST_TABLE_LOOKUP: assert property (
    ce && r.st == ST_IND && r.ind_table_lookup |=>
      r.sc == $past(r.sb) && q_out == $past(rom_q) && r.st == ST_FETCH)
    else $error("table lookup result wrong");

  AST_SKT: assert property (
    fetch_ex && op == OP_SKT && r.tflag |=> r.skip)
    else $error("timer test did not skip");

  AST_SKIPBYTE: assert property (
    ce && r.run && r.st == ST_FETCH && r.skip && !is_pfx(op) |=>
      !r.skip && r.st == ST_FETCH && r.pc == $past(pcn))
    else $error("skipped byte took wrong time");

  AST_CALL_PAGE_TWO: assert property (
    fetch_ex && op[7:6] == 2'h2 && op != OP_TABLE_LOOKUP &&
      pcn[9:7] != SUB_PAGE[3:1] |=>
      r.pc[9:6] == SUB_PAGE && r.sa == $past(pcn))
    else $error("page two call wrong");

endmodule

//--- test_nibble_mcu_instruction_exec.sv
// Self-checking testbench for the nibble MCU execution core
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    cmp_count++; \
    if ((gt) !== (ex)) begin \
      err_total++; \
      $display("FAIL %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module test_nibble_mcu_instruction_exec
  import nme_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n;
  logic ce;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_rdata;
  wire logic [3:0] g_in;
  logic [3:0] g_out;
  logic [3:0] g_oe_n;
  logic [3:0] g_ext;
  logic [7:0] l_in;
  logic in3_pin;
  logic in0_pin;
  logic cko_pin;
  logic cko_gp_opt;
  logic [7:0] q_out;
  logic [3:0] en_out;
  logic sk_out;
  logic [31:0] rd;
  int err_total = 0;
  int cmp_count = 0;

  // Open-drain G wire: pulled low by the core or by the outside world
  assign g_in = g_oe_n & g_ext;

  always #20 clk = ~clk;

  nme_core uut (
    .clk(clk), .reset_n(reset_n), .ce(ce), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .g_in(g_in), .g_out(g_out), .g_oe_n(g_oe_n),
    .l_in(l_in), .in3_pin(in3_pin), .in0_pin(in0_pin), .cko_pin(cko_pin),
    .cko_gp_opt(cko_gp_opt), .q_out(q_out), .en_out(en_out),
    .sk_out(sk_out)
  );

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    d = bus_rdata;
  endtask

  task automatic rom_put(input logic [9:0] a, input logic [7:0] b);
    bus_write(OFF_ROM_ADDR, {22'h000000, a});
    bus_write(OFF_ROM_DATA, {24'h000000, b});
  endtask

  task automatic do_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  task automatic run_for(input int n);
    bus_write(OFF_CTRL, 32'h00000001);
    repeat (n) @(posedge clk);
    bus_write(OFF_CTRL, 32'h00000000);
  endtask

  // Reset, load a program at address 0 and let it run into its end loop
  task automatic run_prog(input logic [7:0] p[$], input int n);
    do_reset();
    bus_write(OFF_ROM_ADDR, 32'h00000000);
    foreach (p[i]) bus_write(OFF_ROM_DATA, {24'h000000, p[i]});
    run_for(n);
  endtask

  task automatic chk_st(input logic [9:0] pc, input logic [3:0] dg,
                        input logic [1:0] rw, input logic [3:0] ac,
                        input logic cy);
    bus_read(OFF_STATUS, rd);
    `CHK("pc", pc, rd[9:0])
    `CHK("digit", dg, rd[13:10])
    `CHK("row", rw, rd[15:14])
    `CHK("acc", ac, rd[19:16])
    `CHK("carry", cy, rd[20])
  endtask

  task automatic t_bus;
    rom_put(10'h100, 8'hAB);
    bus_read(OFF_ROM_ADDR, rd);
    `CHK("rom addr step", 32'h00000101, rd)
    bus_read(8'h40, rd);
    `CHK("unmapped read", 32'h00000000, rd)
  endtask

  task automatic t_pointer;
    run_prog('{8'h00, 8'h32, 8'h1E, 8'h76, 8'h22, 8'h0F, 8'h73, 8'h50,
               8'h17, 8'h00, 8'h04, 8'h00, 8'hCC}, 40);
    chk_st(10'h00C, 4'h0, 2'h1, 4'h6, 1'b1);
  endtask

  task automatic t_direct;
    run_prog('{8'h32, 8'h0F, 8'h1C, 8'h28, 8'h79, 8'h00, 8'h23, 8'h80,
               8'hC8}, 30);
    chk_st(10'h008, 4'h1, 2'h0, 4'h9, 1'b0);
  endtask

  task automatic t_ram_bit;
    run_prog('{8'h32, 8'h00, 8'h0F, 8'h75, 8'h0F, 8'h03, 8'h22, 8'h11,
               8'h32, 8'h13, 8'h32, 8'h01, 8'hCC}, 40);
    chk_st(10'h00C, 4'h0, 2'h0, 4'h0, 1'b1);
  endtask

  task automatic t_gport;
    g_ext <= 4'h4;
    run_prog('{8'h00, 8'h0F, 8'h33, 8'h5F, 8'h33, 8'h6C, 8'h32, 8'h22,
               8'h33, 8'h21, 8'h32, 8'h33, 8'h03, 8'h22, 8'h33, 8'h01,
               8'h32, 8'h33, 8'h11, 8'h32, 8'h33, 8'h13, 8'h33, 8'h55,
               8'h33, 8'h50, 8'h44, 8'h44, 8'h33, 8'h21, 8'h32,
               8'hDF}, 60);
    chk_st(10'h01F, 4'h0, 2'h0, 4'h0, 1'b1);
    `CHK("g_out", 4'h0, g_out)
    `CHK("g_oe_n", 4'h0, g_oe_n)
    `CHK("en_out", 4'hC, en_out)
    g_ext <= 4'hF;
  endtask

  task automatic t_serial;
    rom_put(10'h085, 8'h85);
    run_prog('{8'h0F, 8'h33, 8'h2E, 8'h22, 8'h4F, 8'h06, 8'h85}, 30);
    chk_st(10'h085, 4'h0, 2'h0, 4'h3, 1'b1);
    `CHK("sk_out", 1'b1, sk_out)
  endtask

  task automatic t_pulse;
    run_prog('{8'h32, 8'h0F, 8'h33, 8'h29, 8'hC4}, 20);
    @(posedge clk);
    in3_pin <= 1'b0;
    in0_pin <= 1'b0;
    @(posedge clk);
    in0_pin <= 1'b1;
    repeat (3) @(posedge clk);
    in3_pin <= 1'b1;
    repeat (4) @(posedge clk);
    bus_read(OFF_PORTS, rd);
    `CHK("latches set", 2'b10, rd[21:20])
    do_reset();
    bus_read(OFF_PORTS, rd);
    `CHK("latches kept", 2'b10, rd[21:20])
    run_for(20);
    chk_st(10'h004, 4'h0, 2'h0, 4'h8, 1'b0);
    bus_read(OFF_PORTS, rd);
    `CHK("latches cleared", 2'b00, rd[21:20])
  endtask

  task automatic t_timer;
    run_prog('{8'h00, 8'h0F, 8'h32, 8'h41, 8'h22, 8'hC5}, 20);
    chk_st(10'h005, 4'h0, 2'h0, 4'h0, 1'b1);
    do_reset();
    repeat (1100) @(posedge clk);
    bus_read(OFF_PORTS, rd);
    `CHK("timer flag set", 1'b1, rd[22])
    run_for(20);
    chk_st(10'h005, 4'h0, 2'h0, 4'h0, 1'b0);
    bus_read(OFF_PORTS, rd);
    `CHK("timer flag clear", 1'b0, rd[22])
  endtask

  task automatic t_indirect;
    rom_put(10'h023, 8'h3F);
    rom_put(10'h03F, 8'hC5);
    rom_put(10'h045, 8'hC5);
    run_prog('{8'h32, 8'h0F, 8'h73, 8'h72, 8'h23, 8'h01, 8'h0F, 8'hBF,
               8'hFF}, 40);
    chk_st(10'h045, 4'h0, 2'h0, 4'h2, 1'b0);
    `CHK("q_out", 8'h3F, q_out)
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    $display("FAIL run length expected end seen hang");
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 32'h00000000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    g_ext = 4'hF;
    l_in = 8'h3C;
    in3_pin = 1'b1;
    in0_pin = 1'b1;
    cko_pin = 1'b0;
    cko_gp_opt = 1'b1;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_bus();
    t_pointer();
    t_direct();
    t_ram_bit();
    t_gport();
    t_serial();
    t_pulse();
    t_timer();
    t_indirect();
    complete_run();
  end
endmodule
